// ### include/mfp_pkg.sv
package mfp_pkg;

  // register indexes on the plain register port
  localparam logic [7:0] SEL_LOW_ADDR = 8'h3c;
  localparam logic [7:0] SEL_HIGH_ADDR = 8'h3d;
  localparam logic [7:0] OUT_LEVELS_ADDR = 8'h3e;
  localparam logic [7:0] IN_LEVELS_ADDR = 8'h3f;
  localparam logic [7:0] IO_MODE_ADDR = 8'h38;

  // pin_function_select_low fields (lsb of each 2-bit field)
  localparam int SEL_CLAIM1_LSB = 0;
  localparam int SEL_CLAIM2_LSB = 2;
  localparam int SEL_IN_A_LSB = 4;
  localparam int SEL_OUT_B_LSB = 6;
  // pin_function_select_high fields
  localparam int SEL_ROW6_LSB = 0;
  localparam int SEL_ROW7_LSB = 2;
  localparam int SEL_OUT_C_LSB = 4;
  localparam int SEL_OUT_D_LSB = 6;
  // general_output_levels fields
  localparam int OUT_ROW6_BIT = 0;
  localparam int OUT_ROW7_BIT = 1;
  localparam int OUT_B_BIT = 2;
  localparam int OUT_C_BIT = 3;
  localparam int OUT_D_BIT = 4;
  localparam int OUT_FLUSH_BIT = 5;
  localparam int SEL_FLUSH_LSB = 6;
  // io_select_mode fields, select 1 sits at IO_MODE_CS1_LSB above select 0
  localparam int IO_MODE_STROBE_BIT = 0;
  localparam int IO_MODE_RD_BIT = 1;
  localparam int IO_MODE_WR_BIT = 2;
  localparam int IO_MODE_CS1_LSB = 4;

  // function codes of a 2-bit select field
  localparam logic [1:0] FN_FIRST = 2'h0;
  localparam logic [1:0] FN_SECOND = 2'h1;
  localparam logic [1:0] FN_THIRD = 2'h2;
  localparam logic [1:0] FN_FOURTH = 2'h3;

  // reset values
  localparam logic [7:0] SEL_LOW_RESET = 8'h00;
  localparam logic [7:0] SEL_HIGH_RESET = 8'h00;
  localparam logic [7:0] OUT_LEVELS_RESET = 8'h3f;
  localparam logic [7:0] IO_MODE_RESET = 8'h66;
  localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// ### logic/mfp_pin_select.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps

// Overview of operation
// [RULE1] write policy high unless write-through decode hits
// [RULE2] write policy valid within first T2
// [RULE3] write protect follows decode on memory cycles
// [RULE4] cpu tags line protected when sampled low
// [RULE5] cache select high only during cache cycles
// [RULE6] pin may carry dram address bit 12
// [RULE7] claim inputs 1 and 2 merge with claim 0
// [RULE8] clock speed output high requests slow clock
// [RULE9] io selects: level or strobe, read/write enables
// [RULE10] memory selects follow decode, never strobes
// [RULE11] mouse interrupt may drive pin directly
// [RULE12] keyboard lock low blocks keyboard input
// [RULE13] peripheral select low when A15..A10 zero
// [RULE14] isa buffer enable on isa cycle or grant
// [RULE15] xd route low sends io cycles to xd
// [RULE16] two select registers, four 2-bit fields each
// [RULE17] input pin function codes, 00 plain input
// [RULE18] output register bits 7:6 pick flush function
// [RULE19] output register drives plain output pins
// [RULE20] input register reads live pin levels; the code does not read claim 2, bit 3 reads zero
// [RULE21] mouse pins by enable, stop pin by pm
// [RULE22] selects at 3Ch/3Dh, then output, input
// [RULE23] reset: outputs high, first functions selected
// [RULE24] high select bits 3:2 row7, 1:0 row6
module mfp_pin_select (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // cpu cycle and decode results from the core
  input wire logic WT_DECODE_HIT_IN,
  input wire logic BIOS_WT_HIT_IN,
  input wire logic WP_DECODE_HIT_IN,
  input wire logic MEM_CYCLE_IN,
  input wire logic CACHE_CYCLE_IN,
  input wire logic [5:0] CPU_ADDR_HI_IN,
  input wire logic IO_CYCLE_IN,
  input wire logic IO_READ_IN,
  input wire logic IO_WRITE_IN,
  input wire logic IO_CMD_ACTIVE_IN,
  input wire logic IO_DECODE0_HIT_IN,
  input wire logic IO_DECODE1_HIT_IN,
  input wire logic MEM_DECODE0_HIT_IN,
  input wire logic MEM_DECODE1_HIT_IN,
  // dram, bus and system functions from the core
  input wire logic DRAM_SELECT_N_IN,
  input wire logic DRAM_ADDR_BIT12_IN,
  input wire logic ROW_STROBE6_N_IN,
  input wire logic ROW_STROBE7_N_IN,
  input wire logic FLUSH_N_IN,
  input wire logic AT_CYCLE_ACTIVE_IN,
  input wire logic DMA_MASTER_GRANT_N_IN,
  input wire logic MOUSE_IRQ_IN,
  input wire logic STOP_CLOCK_N_IN,
  input wire logic SLOW_CLOCK_REQUEST_IN,
  input wire logic STOP_PIN_SPEED_SEL_IN,
  input wire logic MOUSE_ENABLE_IN,
  input wire logic MOUSE_CLK_LOW_IN,
  input wire logic MOUSE_DATA_LOW_IN,
  // input pins
  input wire logic LOCAL_CLAIM0_N_PIN_IN,
  input wire logic LOCAL_CLAIM1_N_PIN_IN,
  input wire logic LOCAL_CLAIM2_N_PIN_IN,
  input wire logic MULTI_IN_A_PIN_IN,
  input wire logic MOUSE_CLK_PIN_IN,
  input wire logic MOUSE_DATA_PIN_IN,
  // output pins
  output logic MULTI_OUT_B_PIN_OUT,
  output logic MULTI_OUT_C_PIN_OUT,
  output logic MULTI_OUT_D_PIN_OUT,
  output logic ROW_STROBE6_N_PIN_OUT,
  output logic ROW_STROBE7_N_PIN_OUT,
  output logic FLUSH_N_PIN_OUT,
  output logic STOP_CLOCK_PIN_OUT,
  // open-collector mouse pins
  output logic MOUSE_CLK_OUT,
  output logic MOUSE_CLK_OE_OUT,
  output logic MOUSE_DATA_OUT,
  output logic MOUSE_DATA_OE_OUT,
  // pin functions handed to the core
  output logic LOCAL_CLAIM_N_OUT,
  output logic PM_EVENT0_OUT,
  output logic PM_EVENT1_OUT,
  output logic PM_REF14_OUT,
  output logic KEYBOARD_LOCK_N_OUT,
  output logic IO_ROUTE_XD_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic pick4(input logic [1:0] sel, input logic f1, input logic f2,
                                 input logic f3, input logic f4);
    logic r;
    r = f1;
    case (sel)
      mfp_pkg::FN_FIRST: r = f1;
      mfp_pkg::FN_SECOND: r = f2;
      mfp_pkg::FN_THIRD: r = f3;
      default: r = f4;
    endcase
    return r;
  endfunction

  function automatic logic io_select_active(input logic hit, input logic [2:0] mode, input logic rd,
                                            input logic wr, input logic cmd);
    logic dir_ok;
    dir_ok = (rd & mode[mfp_pkg::IO_MODE_RD_BIT]) | (wr & mode[mfp_pkg::IO_MODE_WR_BIT]);
    return hit & dir_ok & (~mode[mfp_pkg::IO_MODE_STROBE_BIT] | cmd);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] sel_low_q;
  logic [7:0] sel_high_q;
  logic [7:0] out_levels_q;
  logic [7:0] io_mode_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] in_levels;

  wire wr_sel_low = REG_WR_IN && (REG_ADDR_IN == mfp_pkg::SEL_LOW_ADDR);
  wire wr_sel_high = REG_WR_IN && (REG_ADDR_IN == mfp_pkg::SEL_HIGH_ADDR);
  wire wr_out_levels = REG_WR_IN && (REG_ADDR_IN == mfp_pkg::OUT_LEVELS_ADDR);
  wire wr_io_mode = REG_WR_IN && (REG_ADDR_IN == mfp_pkg::IO_MODE_ADDR);

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sel_low_q <= mfp_pkg::SEL_LOW_RESET; // [RULE23]
      sel_high_q <= mfp_pkg::SEL_HIGH_RESET; // [RULE23]
      out_levels_q <= mfp_pkg::OUT_LEVELS_RESET; // [RULE23]
      io_mode_q <= mfp_pkg::IO_MODE_RESET;
    end else begin
      if (wr_sel_low) begin
        sel_low_q <= REG_WDATA_IN; // [RULE16] [RULE22]
      end
      if (wr_sel_high) begin
        sel_high_q <= REG_WDATA_IN; // [RULE16] [RULE22]
      end
      if (wr_out_levels) begin
        out_levels_q <= REG_WDATA_IN; // [RULE18] [RULE19]
      end
      if (wr_io_mode) begin
        io_mode_q <= REG_WDATA_IN;
      end
    end
  end

  // read data stands in the cycle after the strobe only; unmapped reads give zero
  always_comb begin
    rdata_d = mfp_pkg::READ_IDLE;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        mfp_pkg::SEL_LOW_ADDR: rdata_d = sel_low_q;
        mfp_pkg::SEL_HIGH_ADDR: rdata_d = sel_high_q;
        mfp_pkg::OUT_LEVELS_ADDR: rdata_d = out_levels_q;
        mfp_pkg::IN_LEVELS_ADDR: rdata_d = in_levels; // [RULE20] [RULE22]
        mfp_pkg::IO_MODE_ADDR: rdata_d = io_mode_q;
        default: rdata_d = mfp_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_q <= mfp_pkg::READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input pin synchronisers: a change counts once stages two and three agree

  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  logic [5:0] pin_lvl_q;
  wire [5:0] pin_raw = {MOUSE_DATA_PIN_IN, MOUSE_CLK_PIN_IN, MULTI_IN_A_PIN_IN,
                        LOCAL_CLAIM2_N_PIN_IN, LOCAL_CLAIM1_N_PIN_IN, LOCAL_CLAIM0_N_PIN_IN};
  wire [5:0] pin_lvl_d = (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_s1_q <= 6'h3f;
      pin_s2_q <= 6'h3f;
      pin_s3_q <= 6'h3f;
      pin_lvl_q <= 6'h3f;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  wire claim0_n = pin_lvl_q[0];
  wire claim1_n = pin_lvl_q[1];
  wire claim2_n = pin_lvl_q[2];
  wire multi_in_a = pin_lvl_q[3];
  wire mouse_clk = pin_lvl_q[4];
  wire mouse_data = pin_lvl_q[5];

  // levels are read whatever the pin's function; claim 2 is not read, bit 3 reads zero
  assign in_levels = {2'h0, mouse_data, mouse_clk, 1'b0, multi_in_a, claim1_n, claim0_n}; // [RULE20]

  ////////////////////////////////////////////////////////////////////////////
  // select fields

  wire [1:0] sel_claim1 = sel_low_q[mfp_pkg::SEL_CLAIM1_LSB +: 2];
  wire [1:0] sel_claim2 = sel_low_q[mfp_pkg::SEL_CLAIM2_LSB +: 2];
  wire [1:0] sel_in_a = sel_low_q[mfp_pkg::SEL_IN_A_LSB +: 2];
  wire [1:0] sel_out_b = sel_low_q[mfp_pkg::SEL_OUT_B_LSB +: 2];
  wire [1:0] sel_row6 = sel_high_q[mfp_pkg::SEL_ROW6_LSB +: 2]; // [RULE24]
  wire [1:0] sel_row7 = sel_high_q[mfp_pkg::SEL_ROW7_LSB +: 2]; // [RULE24]
  wire [1:0] sel_out_c = sel_high_q[mfp_pkg::SEL_OUT_C_LSB +: 2];
  wire [1:0] sel_out_d = sel_high_q[mfp_pkg::SEL_OUT_D_LSB +: 2];
  wire [1:0] sel_flush = out_levels_q[mfp_pkg::SEL_FLUSH_LSB +: 2]; // [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // function decodes

  wire write_policy = ~(WT_DECODE_HIT_IN | BIOS_WT_HIT_IN); // [RULE1]
  wire write_protect_n = ~(WP_DECODE_HIT_IN & MEM_CYCLE_IN); // [RULE3]
  wire cache_ram_select = CACHE_CYCLE_IN; // [RULE5]
  wire isa_buffer_enable = AT_CYCLE_ACTIVE_IN | ~DMA_MASTER_GRANT_N_IN; // [RULE14]
  wire peripheral_io_select_n = |CPU_ADDR_HI_IN; // [RULE13]
  wire mem_select0_n = ~MEM_DECODE0_HIT_IN; // [RULE10]
  wire mem_select1_n = ~MEM_DECODE1_HIT_IN; // [RULE10]
  wire io_select0_n = ~io_select_active(IO_DECODE0_HIT_IN, io_mode_q[2:0], IO_READ_IN, IO_WRITE_IN,
                                         IO_CMD_ACTIVE_IN); // [RULE9]
  wire io_select1_n = ~io_select_active(IO_DECODE1_HIT_IN,
                                         io_mode_q[mfp_pkg::IO_MODE_CS1_LSB +: 3], IO_READ_IN,
                                         IO_WRITE_IN, IO_CMD_ACTIVE_IN); // [RULE9]

  // input pin functions, inactive level when not selected
  wire claim1_used = (sel_claim1 == mfp_pkg::FN_SECOND) & ~claim1_n;
  wire claim2_used = (sel_claim2 == mfp_pkg::FN_SECOND) & ~claim2_n;
  wire local_claim_n = ~(~claim0_n | claim1_used | claim2_used); // [RULE7]
  wire keyboard_lock_n = (sel_claim2 == mfp_pkg::FN_THIRD) ? claim2_n : 1'b1; // [RULE12] [RULE17]
  wire pm_event1 = (sel_claim2 == mfp_pkg::FN_FOURTH) & claim2_n; // [RULE17]
  wire pm_event0 = (sel_in_a == mfp_pkg::FN_FOURTH) & multi_in_a; // [RULE17]
  wire xd_io_route_n = (sel_in_a == mfp_pkg::FN_THIRD) ? multi_in_a : 1'b1; // [RULE17]
  wire ref14 = ((sel_claim1 == mfp_pkg::FN_THIRD) & claim1_n) |
               ((sel_in_a == mfp_pkg::FN_SECOND) & multi_in_a); // [RULE17]
  wire io_route_xd = IO_CYCLE_IN & ~xd_io_route_n; // [RULE15]

  ////////////////////////////////////////////////////////////////////////////
  // output pin muxes

  // b and c stay combinational: cpu samples them within the first T2 of a zero-wait hit
  assign MULTI_OUT_B_PIN_OUT = pick4(sel_out_b, write_policy, isa_buffer_enable, MOUSE_IRQ_IN,
                                     out_levels_q[mfp_pkg::OUT_B_BIT]); // [RULE2] [RULE11] [RULE19]
  assign MULTI_OUT_C_PIN_OUT = pick4(sel_out_c, write_protect_n, cache_ram_select, io_select0_n,
                                     out_levels_q[mfp_pkg::OUT_C_BIT]); // [RULE3] [RULE19]

  wire out_d_d = pick4(sel_out_d, DRAM_SELECT_N_IN, isa_buffer_enable, io_select1_n,
                       out_levels_q[mfp_pkg::OUT_D_BIT]); // [RULE19]
  wire row6_d = pick4(sel_row6, ROW_STROBE6_N_IN, DRAM_ADDR_BIT12_IN, mem_select0_n,
                      out_levels_q[mfp_pkg::OUT_ROW6_BIT]); // [RULE6] [RULE19]
  wire row7_d = pick4(sel_row7, ROW_STROBE7_N_IN, peripheral_io_select_n, mem_select1_n,
                      out_levels_q[mfp_pkg::OUT_ROW7_BIT]); // [RULE19]
  // reserved flush code parks the pin high
  wire flush_d = pick4(sel_flush, FLUSH_N_IN, 1'b1, io_select0_n,
                       out_levels_q[mfp_pkg::OUT_FLUSH_BIT]); // [RULE18] [RULE19]
  wire stop_pin_d = STOP_PIN_SPEED_SEL_IN ? SLOW_CLOCK_REQUEST_IN : STOP_CLOCK_N_IN; // [RULE8] [RULE21]
  // open collector: only ever pull low while the mouse function owns the pin
  wire mouse_clk_oe_d = MOUSE_ENABLE_IN & MOUSE_CLK_LOW_IN; // [RULE21]
  wire mouse_data_oe_d = MOUSE_ENABLE_IN & MOUSE_DATA_LOW_IN; // [RULE21]

  logic out_d_q;
  logic row6_q;
  logic row7_q;
  logic flush_q;
  logic stop_pin_q;
  logic mouse_clk_oe_q;
  logic mouse_data_oe_q;
  logic local_claim_n_q;
  logic pm_event0_q;
  logic pm_event1_q;
  logic ref14_q;
  logic keyboard_lock_n_q;
  logic io_route_xd_q;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      out_d_q <= 1'b1; // [RULE23]
      row6_q <= 1'b1; // [RULE23]
      row7_q <= 1'b1; // [RULE23]
      flush_q <= 1'b1; // [RULE23]
      stop_pin_q <= 1'b1;
      mouse_clk_oe_q <= 1'b0;
      mouse_data_oe_q <= 1'b0;
      local_claim_n_q <= 1'b1;
      pm_event0_q <= 1'b0;
      pm_event1_q <= 1'b0;
      ref14_q <= 1'b0;
      keyboard_lock_n_q <= 1'b1;
      io_route_xd_q <= 1'b0;
    end else begin
      out_d_q <= out_d_d;
      row6_q <= row6_d;
      row7_q <= row7_d;
      flush_q <= flush_d;
      stop_pin_q <= stop_pin_d;
      mouse_clk_oe_q <= mouse_clk_oe_d;
      mouse_data_oe_q <= mouse_data_oe_d;
      local_claim_n_q <= local_claim_n;
      pm_event0_q <= pm_event0;
      pm_event1_q <= pm_event1;
      ref14_q <= ref14;
      keyboard_lock_n_q <= keyboard_lock_n;
      io_route_xd_q <= io_route_xd;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign MULTI_OUT_D_PIN_OUT = out_d_q;
  assign ROW_STROBE6_N_PIN_OUT = row6_q;
  assign ROW_STROBE7_N_PIN_OUT = row7_q;
  assign FLUSH_N_PIN_OUT = flush_q;
  assign STOP_CLOCK_PIN_OUT = stop_pin_q;
  assign MOUSE_CLK_OUT = 1'b0;
  assign MOUSE_CLK_OE_OUT = mouse_clk_oe_q;
  assign MOUSE_DATA_OUT = 1'b0;
  assign MOUSE_DATA_OE_OUT = mouse_data_oe_q;
  assign LOCAL_CLAIM_N_OUT = local_claim_n_q;
  assign PM_EVENT0_OUT = pm_event0_q;
  assign PM_EVENT1_OUT = pm_event1_q;
  assign PM_REF14_OUT = ref14_q;
  assign KEYBOARD_LOCK_N_OUT = keyboard_lock_n_q;
  assign IO_ROUTE_XD_OUT = io_route_xd_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  a_policy_default: assert property ((sel_out_b == mfp_pkg::FN_FIRST) |-> // [RULE1]
    (MULTI_OUT_B_PIN_OUT == !(WT_DECODE_HIT_IN || BIOS_WT_HIT_IN)))
    else $error("write policy pin wrong");
  a_protect_memory: assert property ((sel_out_c == mfp_pkg::FN_FIRST) |-> // [RULE3]
    (MULTI_OUT_C_PIN_OUT == !(WP_DECODE_HIT_IN && MEM_CYCLE_IN)))
    else $error("write protect pin wrong");
  a_cache_idle: assert property ((sel_out_c == mfp_pkg::FN_SECOND && !CACHE_CYCLE_IN) |-> // [RULE5]
    !MULTI_OUT_C_PIN_OUT)
    else $error("cache select active between cycles");
  a_claim_merge: assert property ((sel_claim2 == mfp_pkg::FN_SECOND && !claim2_n) |=> // [RULE7]
    !LOCAL_CLAIM_N_OUT)
    else $error("claim 2 not merged");
  a_memsel_match: assert property ((sel_row6 == mfp_pkg::FN_THIRD && $stable(sel_high_q)) |=> // [RULE10]
    (ROW_STROBE6_N_PIN_OUT == !$past(MEM_DECODE0_HIT_IN)))
    else $error("memory select 0 wrong");
  a_periph_decode: assert property ((sel_row7 == mfp_pkg::FN_SECOND && $stable(sel_high_q)) |=> // [RULE13]
    (ROW_STROBE7_N_PIN_OUT == ($past(CPU_ADDR_HI_IN) != 6'h00)))
    else $error("peripheral select decode wrong");
  a_isa_enable: assert property ((sel_out_d == mfp_pkg::FN_SECOND && $stable(sel_high_q)) |=> // [RULE14]
    (MULTI_OUT_D_PIN_OUT == ($past(AT_CYCLE_ACTIVE_IN) || !$past(DMA_MASTER_GRANT_N_IN))))
    else $error("isa buffer enable wrong");
  a_plain_out: assert property (wr_out_levels ##1 (sel_flush == mfp_pkg::FN_FOURTH && !wr_out_levels) |=> // [RULE19]
    (FLUSH_N_PIN_OUT == $past(out_levels_q[mfp_pkg::OUT_FLUSH_BIT])))
    else $error("plain output level not driven");
  a_read_inputs: assert property ((REG_RD_IN && REG_ADDR_IN == mfp_pkg::IN_LEVELS_ADDR) |=> // [RULE20]
    (REG_RDATA_OUT == {2'h0, $past(mouse_data), $past(mouse_clk), 1'b0, $past(multi_in_a),
                       $past(claim1_n), $past(claim0_n)}))
    else $error("input levels read wrong");
  a_read_idle: assert property (!REG_RD_IN |=> (REG_RDATA_OUT == mfp_pkg::READ_IDLE)) // [RULE22]
    else $error("read data outside answer cycle");
  a_xd_route: assert property ((sel_in_a == mfp_pkg::FN_THIRD && !multi_in_a && IO_CYCLE_IN) |=> // [RULE15]
    IO_ROUTE_XD_OUT)
    else $error("io cycle not routed to xd bus");

  c_isa_enable: cover property ((sel_out_d == mfp_pkg::FN_SECOND) ##1 MULTI_OUT_D_PIN_OUT);
  c_plain_write: cover property (wr_out_levels ##1 (sel_flush == mfp_pkg::FN_FOURTH) ##1 !FLUSH_N_PIN_OUT);
  c_xd_route: cover property (IO_ROUTE_XD_OUT);
  c_input_read: cover property (REG_RD_IN && REG_ADDR_IN == mfp_pkg::IN_LEVELS_ADDR);

endmodule

// ### tb/mfp_board_model.sv
`timescale 1ns/1ps

module mfp_board_model (
  // clock and bench controls
  input wire logic clk_in,
  input wire logic [3:0] level_in,
  input wire logic ready_in,
  // lines from the device
  input wire logic protect_n_in,
  input wire logic mclk_oe_in,
  input wire logic mouse_data_oe_in,
  // lines to the device, and the cpu tag bit back to the bench
  output logic claim0_n_out,
  output logic claim1_n_out,
  output logic claim2_n_out,
  output logic in_a_out,
  output logic mclk_out,
  output logic mouse_data_out,
  output logic line_protected_out
);
  ////////////////////////////////////////////////////////////////
  // claim and event pins follow the levels the bench asks for
  assign {in_a_out, claim2_n_out, claim1_n_out, claim0_n_out} = level_in;
  // board pull-ups: a released line reads high, never the last value
  assign mclk_out = ~mclk_oe_in;
  assign mouse_data_out = ~mouse_data_oe_in;
  ////////////////////////////////////////////////////////////////
  // cpu tag bit captured with each ready of a line fill
  always_ff @(posedge clk_in) begin
    if (ready_in) begin
      line_protected_out <= ~protect_n_in;
    end
  end
endmodule

// ### tb/multifunction_pin_select_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end

module multifunction_pin_select_bench;
  logic REF_CLK_IN = 1'h0, RESET_N_IN = 1'h0, REG_WR_IN = 1'h0, REG_RD_IN = 1'h0, fill_ready = 1'h0;
  logic [7:0] REG_ADDR_IN = 8'h00, REG_WDATA_IN = 8'h00, REG_RDATA_OUT, v;
  logic [5:0] CPU_ADDR_HI_IN = 6'h3f;
  logic [3:0] level = 4'hf;
  logic WT_DECODE_HIT_IN = 1'h0, BIOS_WT_HIT_IN = 1'h0, WP_DECODE_HIT_IN = 1'h0, MEM_CYCLE_IN = 1'h0;
  logic CACHE_CYCLE_IN = 1'h0, IO_CYCLE_IN = 1'h0, IO_READ_IN = 1'h0, IO_WRITE_IN = 1'h0;
  logic IO_CMD_ACTIVE_IN = 1'h0, IO_DECODE0_HIT_IN = 1'h0, IO_DECODE1_HIT_IN = 1'h0;
  logic MEM_DECODE0_HIT_IN = 1'h0, MEM_DECODE1_HIT_IN = 1'h0, DRAM_SELECT_N_IN = 1'h1, DRAM_ADDR_BIT12_IN = 1'h0;
  logic ROW_STROBE6_N_IN = 1'h1, ROW_STROBE7_N_IN = 1'h1, FLUSH_N_IN = 1'h1, AT_CYCLE_ACTIVE_IN = 1'h0;
  logic DMA_MASTER_GRANT_N_IN = 1'h1, MOUSE_IRQ_IN = 1'h0, STOP_CLOCK_N_IN = 1'h1, SLOW_CLOCK_REQUEST_IN = 1'h0;
  logic STOP_PIN_SPEED_SEL_IN = 1'h0, MOUSE_ENABLE_IN = 1'h0, MOUSE_CLK_LOW_IN = 1'h0, MOUSE_DATA_LOW_IN = 1'h0;
  logic LOCAL_CLAIM0_N_PIN_IN, LOCAL_CLAIM1_N_PIN_IN, LOCAL_CLAIM2_N_PIN_IN, MULTI_IN_A_PIN_IN;
  logic MOUSE_CLK_PIN_IN, MOUSE_DATA_PIN_IN, MULTI_OUT_B_PIN_OUT, MULTI_OUT_C_PIN_OUT, MULTI_OUT_D_PIN_OUT;
  logic ROW_STROBE6_N_PIN_OUT, ROW_STROBE7_N_PIN_OUT, FLUSH_N_PIN_OUT, STOP_CLOCK_PIN_OUT, MOUSE_CLK_OUT;
  logic MOUSE_CLK_OE_OUT, MOUSE_DATA_OUT, MOUSE_DATA_OE_OUT, LOCAL_CLAIM_N_OUT, PM_EVENT0_OUT, PM_EVENT1_OUT;
  logic PM_REF14_OUT, KEYBOARD_LOCK_N_OUT, IO_ROUTE_XD_OUT, line_prot;
  int fails = 0;
  int check_count = 0;

  mfp_pin_select i_mfp_pin_select (.REF_CLK_IN, .RESET_N_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN,
    .REG_RDATA_OUT, .WT_DECODE_HIT_IN, .BIOS_WT_HIT_IN, .WP_DECODE_HIT_IN, .MEM_CYCLE_IN, .CACHE_CYCLE_IN,
    .CPU_ADDR_HI_IN, .IO_CYCLE_IN, .IO_READ_IN, .IO_WRITE_IN, .IO_CMD_ACTIVE_IN, .IO_DECODE0_HIT_IN,
    .IO_DECODE1_HIT_IN, .MEM_DECODE0_HIT_IN, .MEM_DECODE1_HIT_IN, .DRAM_SELECT_N_IN, .DRAM_ADDR_BIT12_IN,
    .ROW_STROBE6_N_IN, .ROW_STROBE7_N_IN, .FLUSH_N_IN, .AT_CYCLE_ACTIVE_IN, .DMA_MASTER_GRANT_N_IN, .MOUSE_IRQ_IN,
    .STOP_CLOCK_N_IN, .SLOW_CLOCK_REQUEST_IN, .STOP_PIN_SPEED_SEL_IN, .MOUSE_ENABLE_IN, .MOUSE_CLK_LOW_IN,
    .MOUSE_DATA_LOW_IN, .LOCAL_CLAIM0_N_PIN_IN, .LOCAL_CLAIM1_N_PIN_IN, .LOCAL_CLAIM2_N_PIN_IN,
    .MULTI_IN_A_PIN_IN, .MOUSE_CLK_PIN_IN, .MOUSE_DATA_PIN_IN, .MULTI_OUT_B_PIN_OUT, .MULTI_OUT_C_PIN_OUT,
    .MULTI_OUT_D_PIN_OUT, .ROW_STROBE6_N_PIN_OUT, .ROW_STROBE7_N_PIN_OUT, .FLUSH_N_PIN_OUT, .STOP_CLOCK_PIN_OUT,
    .MOUSE_CLK_OUT, .MOUSE_CLK_OE_OUT, .MOUSE_DATA_OUT, .MOUSE_DATA_OE_OUT, .LOCAL_CLAIM_N_OUT, .PM_EVENT0_OUT,
    .PM_EVENT1_OUT, .PM_REF14_OUT, .KEYBOARD_LOCK_N_OUT, .IO_ROUTE_XD_OUT);

  mfp_board_model i_mfp_board_model (.clk_in(REF_CLK_IN), .level_in(level), .ready_in(fill_ready),
    .protect_n_in(MULTI_OUT_C_PIN_OUT), .mclk_oe_in(MOUSE_CLK_OE_OUT), .mouse_data_oe_in(MOUSE_DATA_OE_OUT),
    .claim0_n_out(LOCAL_CLAIM0_N_PIN_IN), .claim1_n_out(LOCAL_CLAIM1_N_PIN_IN),
    .claim2_n_out(LOCAL_CLAIM2_N_PIN_IN), .in_a_out(MULTI_IN_A_PIN_IN), .mclk_out(MOUSE_CLK_PIN_IN),
    .mouse_data_out(MOUSE_DATA_PIN_IN), .line_protected_out(line_prot));

  always #12.5 REF_CLK_IN = ~REF_CLK_IN;

  ////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK_IN);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK_IN);
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    REG_WR_IN <= 1'h1;
    @(posedge REF_CLK_IN);
    REG_WR_IN <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge REF_CLK_IN);
    REG_ADDR_IN <= a;
    REG_RD_IN <= 1'h1;
    @(posedge REF_CLK_IN);
    REG_RD_IN <= 1'h0;
    #1;
    d = REG_RDATA_OUT;
  endtask

  task automatic give_verdict();
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h3c, v); `CHK(v, 8'h00)
    rd(8'h3d, v); `CHK(v, 8'h00)
    rd(8'h3e, v); `CHK(v, 8'h3f)
    wr(8'h3f, 8'h00);
    rd(8'h3f, v); `CHK(v, 8'h37)
    rd(8'h3b, v); `CHK(v, 8'h00)
    `CHK({MULTI_OUT_D_PIN_OUT, ROW_STROBE6_N_PIN_OUT, ROW_STROBE7_N_PIN_OUT, FLUSH_N_PIN_OUT}, 4'hf)
  endtask

  task automatic t_policy();
    `CHK(MULTI_OUT_B_PIN_OUT, 1'h1)
    step(1); WT_DECODE_HIT_IN <= 1'h1; #1;
    `CHK(MULTI_OUT_B_PIN_OUT, 1'h0)
    step(1); WT_DECODE_HIT_IN <= 1'h0; BIOS_WT_HIT_IN <= 1'h1; WP_DECODE_HIT_IN <= 1'h1; #1;
    `CHK({MULTI_OUT_B_PIN_OUT, MULTI_OUT_C_PIN_OUT}, 2'h1)
    step(1); MEM_CYCLE_IN <= 1'h1; fill_ready <= 1'h1; #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h0)
    step(1); fill_ready <= 1'h0; MEM_CYCLE_IN <= 1'h0; WP_DECODE_HIT_IN <= 1'h0; BIOS_WT_HIT_IN <= 1'h0; #1;
    `CHK(line_prot, 1'h1)
  endtask

  task automatic t_chip_sel();
    wr(8'h3d, 8'h10); #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h0)
    step(1); CACHE_CYCLE_IN <= 1'h1; #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h1)
    wr(8'h3d, 8'h20); CACHE_CYCLE_IN <= 1'h0; IO_CYCLE_IN <= 1'h1; IO_WRITE_IN <= 1'h1; IO_DECODE0_HIT_IN <= 1'h1;
    step(1); #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h0)
    step(1); IO_DECODE0_HIT_IN <= 1'h0; IO_CYCLE_IN <= 1'h0; IO_WRITE_IN <= 1'h0; #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h1)
    // select 0 as a write-only strobe: reads and writes outside the command window stay quiet
    wr(8'h38, 8'h65); IO_DECODE0_HIT_IN <= 1'h1; IO_READ_IN <= 1'h1;
    step(1); #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h1)
    step(1); IO_READ_IN <= 1'h0; IO_WRITE_IN <= 1'h1; #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h1)
    step(1); IO_CMD_ACTIVE_IN <= 1'h1; #1;
    `CHK(MULTI_OUT_C_PIN_OUT, 1'h0)
    step(1); IO_CMD_ACTIVE_IN <= 1'h0; IO_WRITE_IN <= 1'h0; IO_DECODE0_HIT_IN <= 1'h0;
  endtask

  task automatic t_plain();
    wr(8'h3c, 8'hc0);
    wr(8'h3d, 8'hff);
    wr(8'h3e, 8'hea);
    step(2); #1;
    `CHK({FLUSH_N_PIN_OUT, MULTI_OUT_D_PIN_OUT, MULTI_OUT_C_PIN_OUT, MULTI_OUT_B_PIN_OUT,
      ROW_STROBE7_N_PIN_OUT, ROW_STROBE6_N_PIN_OUT}, 6'h2a)
    wr(8'h3e, 8'hd5);
    step(2); #1;
    `CHK({FLUSH_N_PIN_OUT, MULTI_OUT_D_PIN_OUT, MULTI_OUT_C_PIN_OUT, MULTI_OUT_B_PIN_OUT,
      ROW_STROBE7_N_PIN_OUT, ROW_STROBE6_N_PIN_OUT}, 6'h15)
  endtask

  task automatic t_row_pins();
    wr(8'h3d, 8'h06); CPU_ADDR_HI_IN <= 6'h00; MEM_DECODE0_HIT_IN <= 1'h1;
    step(2); #1;
    `CHK({ROW_STROBE7_N_PIN_OUT, ROW_STROBE6_N_PIN_OUT}, 2'h0)
    step(1); CPU_ADDR_HI_IN <= 6'h20; MEM_DECODE0_HIT_IN <= 1'h0;
    step(2); #1;
    `CHK({ROW_STROBE7_N_PIN_OUT, ROW_STROBE6_N_PIN_OUT}, 2'h3)
    wr(8'h3d, 8'h01); DRAM_ADDR_BIT12_IN <= 1'h1; DRAM_SELECT_N_IN <= 1'h0;
    step(2); #1;
    `CHK({ROW_STROBE6_N_PIN_OUT, MULTI_OUT_D_PIN_OUT}, 2'h2)
    step(1); DRAM_SELECT_N_IN <= 1'h1;
  endtask

  task automatic t_isa();
    wr(8'h3c, 8'h40); #1;
    `CHK(MULTI_OUT_B_PIN_OUT, 1'h0)
    step(1); AT_CYCLE_ACTIVE_IN <= 1'h1; #1;
    `CHK(MULTI_OUT_B_PIN_OUT, 1'h1)
    step(1); AT_CYCLE_ACTIVE_IN <= 1'h0; DMA_MASTER_GRANT_N_IN <= 1'h0; #1;
    `CHK(MULTI_OUT_B_PIN_OUT, 1'h1)
    wr(8'h3d, 8'h40);
    step(1); #1;
    `CHK({MULTI_OUT_D_PIN_OUT, MULTI_OUT_B_PIN_OUT}, 2'h3)
    wr(8'h3c, 8'h80); DMA_MASTER_GRANT_N_IN <= 1'h1; MOUSE_IRQ_IN <= 1'h1;
    step(1); #1;
    `CHK({MULTI_OUT_B_PIN_OUT, MULTI_OUT_D_PIN_OUT}, 2'h2)
  endtask

  // pins pass three synchroniser flops, a level flop and an output flop
  task automatic t_inputs();
    wr(8'h3c, 8'h25); level <= 4'hb;
    step(7); #1;
    `CHK(LOCAL_CLAIM_N_OUT, 1'h0)
    step(1); level <= 4'h7; IO_CYCLE_IN <= 1'h1;
    step(7); #1;
    `CHK({LOCAL_CLAIM_N_OUT, IO_ROUTE_XD_OUT}, 2'h3)
    wr(8'h3c, 8'h38); level <= 4'hb;
    step(7); #1;
    `CHK({KEYBOARD_LOCK_N_OUT, PM_EVENT0_OUT}, 2'h1)
    step(1); MOUSE_ENABLE_IN <= 1'h1; MOUSE_CLK_LOW_IN <= 1'h1; level <= 4'hf;
    step(7);
    rd(8'h3f, v); `CHK(v, 8'h27)
    `CHK({MOUSE_CLK_OE_OUT, MOUSE_DATA_OE_OUT, MOUSE_CLK_OUT, MOUSE_DATA_OUT}, 4'h8)
    wr(8'h3c, 8'h1e); STOP_CLOCK_N_IN <= 1'h0;
    step(2); #1;
    `CHK({PM_EVENT1_OUT, PM_REF14_OUT, KEYBOARD_LOCK_N_OUT, STOP_CLOCK_PIN_OUT}, 4'he)
    step(1); STOP_PIN_SPEED_SEL_IN <= 1'h1; SLOW_CLOCK_REQUEST_IN <= 1'h1;
    step(2); #1;
    `CHK(STOP_CLOCK_PIN_OUT, 1'h1)
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge REF_CLK_IN);
    RESET_N_IN <= 1'h1;
    t_reset();
    t_policy();
    t_chip_sel();
    t_plain();
    t_row_pins();
    t_isa();
    t_inputs();
    give_verdict();
  end
endmodule
